// >>> hw/aicc_dev.sv
`timescale 1ns/1ps
module aicc_dev
  import aicc_pkg::*;
#(
  parameter int SAMPLE_CYC = AICC_SAMPLE_CYC,
  parameter int CONV_CYC = AICC_CONV_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Local bus
  aicc_if.dev bus,
  // Analog front end controls
  output logic [4:0] mux_sel,
  output logic mux_diff,
  output logic [1:0] pga_gain,
  output logic sh_hold,
  output logic sar_start,
  // Converter data from the analog side
  input wire logic [11:0] adc_raw,
  input wire logic adc_done
);

  // ---------------------------------------------------------------------------
  // Types and state
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {AICC_IDLE, AICC_SAMPLE, AICC_CONVERT} aicc_state_t;

  aicc_state_t state_reg;        // Sequencer state.
  logic [31:0] cnt_reg;          // Phase timer.
  logic [11:0] result_reg;       // Last completed result.
  logic eoc_reg;                 // End-of-conversion flag.
  logic cmd_wr;                  // Decoded command write.
  logic rd_low;                  // Decoded low byte read.
  logic rd_high;                 // Decoded high byte read.
  logic [11:0] coded;            // Result in host coding.

  // ---------------------------------------------------------------------------
  // Port decode
  // ---------------------------------------------------------------------------
  // Only strobed accesses to our ports act; other writes are ignored and other reads answer zero.
  assign cmd_wr = bus.io_wr && (bus.io_addr == AICC_PORT_CMD);
  assign rd_low = bus.io_rd && (bus.io_addr == AICC_PORT_LOW);
  assign rd_high = bus.io_rd && (bus.io_addr == AICC_PORT_HIGH);

  // ---------------------------------------------------------------------------
  // Command latch
  // ---------------------------------------------------------------------------
  // Channel, gain and mode are latched by the same write that starts.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mux_sel <= 5'h00;
      mux_diff <= 1'b0;
      pga_gain <= 2'h0;
    end else if (cmd_wr) begin
      // Bipolar mode uses only 16 differential pairs, so the top bit drops.
      mux_diff <= bus.io_wdata[AICC_CMD_BIPOLAR_BIT];
      mux_sel <= bus.io_wdata[AICC_CMD_BIPOLAR_BIT] ?
                 {1'b0, bus.io_wdata[AICC_CMD_CH_LSB +: 4]} :
                 bus.io_wdata[AICC_CMD_CH_LSB +: AICC_CMD_CH_W];
      pga_gain <= bus.io_wdata[AICC_CMD_GAIN_LSB +: 2];
    end
  end

  // ---------------------------------------------------------------------------
  // Conversion sequencer
  // ---------------------------------------------------------------------------
  // A command during a conversion restarts the sequence on the new channel;
  // the old conversion is abandoned rather than queued.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= AICC_IDLE;
      cnt_reg <= 32'h0;
    end else if (cmd_wr) begin
      state_reg <= AICC_SAMPLE;
      cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        AICC_IDLE: begin
          cnt_reg <= 32'h0;
        end
        AICC_SAMPLE: begin
          // Track the input for the full acquisition time before holding.
          if (cnt_reg == 32'(SAMPLE_CYC - 1)) begin
            state_reg <= AICC_CONVERT;
            cnt_reg <= 32'h0;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        AICC_CONVERT: begin
          // The converter's done or the worst-case bound ends the phase,
          // so a silent converter cannot hang the section.
          if (adc_done || cnt_reg == 32'(CONV_CYC - 1)) begin
            state_reg <= AICC_IDLE;
            cnt_reg <= 32'h0;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        default: begin
          state_reg <= AICC_IDLE;
          cnt_reg <= 32'h0;
        end
      endcase
    end
  end

  // Hold and start lines follow the sequencer directly. Hold rises in the
  // same cycle as the start pulse, so the converter never begins on a
  // tracking input and the acquisition time is not cut short by a cycle.
  // Hold drops one cycle after completion, when the sequencer is idle again.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sh_hold <= 1'b0;
      sar_start <= 1'b0;
    end else begin
      sh_hold <= ((state_reg == AICC_CONVERT) ||
                  ((state_reg == AICC_SAMPLE) && (cnt_reg == 32'(SAMPLE_CYC - 1)))) &&
                 !cmd_wr;
      sar_start <= (state_reg == AICC_SAMPLE) && !cmd_wr &&
                   (cnt_reg == 32'(SAMPLE_CYC - 1));
    end
  end

  // ---------------------------------------------------------------------------
  // Result and flag
  // ---------------------------------------------------------------------------
  // Bipolar: raw is offset binary; convert to sign plus 11-bit magnitude.
  // The most negative raw code has no 11-bit magnitude and reads back as a
  // negative zero; the range loses that one code by design.
  always_comb begin
    if (mux_diff) begin
      if (adc_raw[11]) begin
        coded = {1'b0, adc_raw[10:0]};
      end else begin
        coded = {1'b1, 11'(12'h800 - adc_raw)};
      end
    end else begin
      coded = adc_raw;
    end
  end

  // Result changes only at completion so the two byte reads pair up.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_reg <= 12'h000;
    end else if (state_reg == AICC_CONVERT && !cmd_wr &&
                 (adc_done || cnt_reg == 32'(CONV_CYC - 1))) begin
      result_reg <= coded;
    end
  end

  // Flag drops on a start and rises when that conversion's result latches.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      eoc_reg <= 1'b0;
    end else if (cmd_wr) begin
      eoc_reg <= 1'b0;
    end else if (state_reg == AICC_CONVERT &&
                 (adc_done || cnt_reg == 32'(CONV_CYC - 1))) begin
      eoc_reg <= 1'b1;
    end
  end

  assign bus.eoc_irq = eoc_reg;

  // ---------------------------------------------------------------------------
  // Read answer
  // ---------------------------------------------------------------------------
  // Answer one cycle after the strobe; unmapped reads answer zero. The data
  // lines keep the last answer until the next read, so a reader that
  // samples late still sees what it asked for.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus.io_rdata <= 8'h00;
      bus.io_rvalid <= 1'b0;
    end else begin
      bus.io_rvalid <= bus.io_rd;
      if (rd_low) begin
        bus.io_rdata <= result_reg[7:0];
      end else if (rd_high) begin
        bus.io_rdata <= {eoc_reg, state_reg != AICC_IDLE, 2'h0,
                         result_reg[11:8]};
      end else if (bus.io_rd) begin
        // A read of any other port answers zero.
        bus.io_rdata <= 8'h00;
      end
    end
  end

endmodule

// >>> pkg/aicc_pkg.sv
package aicc_pkg;

  // ---------------------------------------------------------------------------
  // Port map of the converter on the local I/O bus
  // ---------------------------------------------------------------------------
  localparam logic [7:0] AICC_PORT_CMD = 8'h00;     // Write: channel, gain, mode, start.
  localparam logic [7:0] AICC_PORT_LOW = 8'h00;     // Read: result bits 7..0.
  localparam logic [7:0] AICC_PORT_HIGH = 8'h01;    // Read: status and result bits 11..8.

  // ---------------------------------------------------------------------------
  // Command byte layout
  // ---------------------------------------------------------------------------
  localparam int AICC_CMD_CH_LSB = 0;               // Channel field, five bits.
  localparam int AICC_CMD_CH_W = 5;
  localparam int AICC_CMD_GAIN_LSB = 5;             // Gain code, two bits.
  localparam int AICC_CMD_BIPOLAR_BIT = 7;          // One selects bipolar operation.

  // ---------------------------------------------------------------------------
  // High byte layout
  // ---------------------------------------------------------------------------
  localparam int AICC_HI_EOC_BIT = 7;               // End-of-conversion flag.
  localparam int AICC_HI_BUSY_BIT = 6;              // Conversion in progress.

  // ---------------------------------------------------------------------------
  // Gain codes
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {
    AICC_GAIN_1 = 2'h0,
    AICC_GAIN_5 = 2'h1,
    AICC_GAIN_50 = 2'h2,
    AICC_GAIN_250 = 2'h3
  } aicc_gain_t;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int AICC_CLK_MHZ = 100;                // sys_clk rate.
  localparam int AICC_SAMPLE_US = 15;               // Sample-and-hold acquisition time.
  localparam int AICC_CONV_US = 50;                 // Longest conversion time.
  localparam int AICC_SAMPLE_CYC = AICC_SAMPLE_US * AICC_CLK_MHZ;
  localparam int AICC_CONV_CYC = AICC_CONV_US * AICC_CLK_MHZ;
  localparam int AICC_RES_W = 12;                   // Result width.

  // Host settling waits per gain, microseconds and cycles.
  localparam int AICC_SETTLE1_US = 55;
  localparam int AICC_SETTLE5_US = 5000;
  localparam int AICC_SETTLE50_US = 250000;
  localparam int AICC_SETTLE250_US = 20000;
  localparam int AICC_SETTLE1_CYC = AICC_SETTLE1_US * AICC_CLK_MHZ;
  localparam int AICC_SETTLE5_CYC = AICC_SETTLE5_US * AICC_CLK_MHZ;
  localparam int AICC_SETTLE50_CYC = AICC_SETTLE50_US * AICC_CLK_MHZ;
  localparam int AICC_SETTLE250_CYC = AICC_SETTLE250_US * AICC_CLK_MHZ;

endpackage

// >>> pkg/aicc_if.sv
`timescale 1ns/1ps
// Local I/O bus between processor and converter section.
interface aicc_if;
  logic [7:0] io_addr;   // Port address.
  logic io_wr;           // One-cycle write strobe.
  logic io_rd;           // One-cycle read strobe.
  logic [7:0] io_wdata;  // Write data.
  logic [7:0] io_rdata;  // Read data, valid the cycle after io_rd.
  logic io_rvalid;       // Read answer strobe.
  logic eoc_irq;         // End-of-conversion interrupt request, level.

  modport dev (
    input io_addr, io_wr, io_rd, io_wdata,
    output io_rdata, io_rvalid, eoc_irq
  );
  modport host (
    output io_addr, io_wr, io_rd, io_wdata,
    input io_rdata, io_rvalid, eoc_irq
  );
endinterface

// >>> hw/aicc_host.sv
`timescale 1ns/1ps
// Processor end: issues one start command, waits, reads both bytes.
module aicc_host
  import aicc_pkg::*;
#(
  parameter int SETTLE1_CYC = AICC_SETTLE1_CYC,
  parameter int SETTLE5_CYC = AICC_SETTLE5_CYC,
  parameter int SETTLE50_CYC = AICC_SETTLE50_CYC,
  parameter int SETTLE250_CYC = AICC_SETTLE250_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Local bus
  aicc_if.host bus,
  // User request
  input wire logic req_valid,
  input wire logic [7:0] req_cmd,
  input wire logic req_use_irq,
  output logic req_ready,
  // Result
  output logic [11:0] res_data,
  output logic res_valid
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    AICC_H_IDLE, AICC_H_WAIT, AICC_H_POLL, AICC_H_RDLO, AICC_H_RDHI, AICC_H_SETTLE
  } aicc_hstate_t;

  aicc_hstate_t state_reg;
  logic [31:0] cnt_reg;          // Settling counter.
  logic [31:0] settle_reg;       // Settling length for this gain.
  logic irq_mode_reg;            // Wait by interrupt instead of polling.
  logic pend_reg;                // A read is outstanding.

  // Per-gain minimum time between successive starts.
  function automatic logic [31:0] settle_of(input logic [1:0] g);
    case (g)
      AICC_GAIN_5: settle_of = 32'(SETTLE5_CYC);
      AICC_GAIN_50: settle_of = 32'(SETTLE50_CYC);
      AICC_GAIN_250: settle_of = 32'(SETTLE250_CYC);
      default: settle_of = 32'(SETTLE1_CYC);
    endcase
  endfunction

  assign req_ready = (state_reg == AICC_H_IDLE);

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= AICC_H_IDLE;
      cnt_reg <= 32'h0;
      settle_reg <= 32'h0;
      irq_mode_reg <= 1'b0;
      pend_reg <= 1'b0;
      bus.io_addr <= 8'h00;
      bus.io_wr <= 1'b0;
      bus.io_rd <= 1'b0;
      bus.io_wdata <= 8'h00;
      res_data <= 12'h000;
      res_valid <= 1'b0;
    end else begin
      bus.io_wr <= 1'b0;
      bus.io_rd <= 1'b0;
      res_valid <= 1'b0;
      cnt_reg <= cnt_reg + 32'h1;
      case (state_reg)
        AICC_H_IDLE: begin
          if (req_valid) begin
            // One write both selects the channel and starts.
            bus.io_addr <= AICC_PORT_CMD;
            bus.io_wdata <= req_cmd;
            bus.io_wr <= 1'b1;
            irq_mode_reg <= req_use_irq;
            settle_reg <= settle_of(req_cmd[AICC_CMD_GAIN_LSB +: 2]);
            cnt_reg <= 32'h0;
            state_reg <= AICC_H_WAIT;
          end
        end
        AICC_H_WAIT: begin
          // Skip the cycle where the device has not yet seen the start.
          state_reg <= irq_mode_reg ? AICC_H_WAIT : AICC_H_POLL;
          if (irq_mode_reg && bus.eoc_irq && cnt_reg > 32'h1) begin
            state_reg <= AICC_H_RDLO;
          end
          pend_reg <= 1'b0;
        end
        AICC_H_POLL: begin
          // Poll the flag in the high byte until it is set.
          if (!pend_reg) begin
            bus.io_addr <= AICC_PORT_HIGH;
            bus.io_rd <= 1'b1;
            pend_reg <= 1'b1;
          end else if (bus.io_rvalid) begin
            pend_reg <= 1'b0;
            if (bus.io_rdata[AICC_HI_EOC_BIT]) begin
              state_reg <= AICC_H_RDLO;
            end
          end
        end
        AICC_H_RDLO: begin
          if (!pend_reg) begin
            bus.io_addr <= AICC_PORT_LOW;
            bus.io_rd <= 1'b1;
            pend_reg <= 1'b1;
          end else if (bus.io_rvalid) begin
            res_data[7:0] <= bus.io_rdata;
            pend_reg <= 1'b0;
            state_reg <= AICC_H_RDHI;
          end
        end
        AICC_H_RDHI: begin
          if (!pend_reg) begin
            bus.io_addr <= AICC_PORT_HIGH;
            bus.io_rd <= 1'b1;
            pend_reg <= 1'b1;
          end else if (bus.io_rvalid) begin
            res_data[11:8] <= bus.io_rdata[3:0];
            res_valid <= 1'b1;
            pend_reg <= 1'b0;
            state_reg <= AICC_H_SETTLE;
          end
        end
        AICC_H_SETTLE: begin
          // Enforce per-sample time measured from the start write.
          if (cnt_reg >= settle_reg) begin
            state_reg <= AICC_H_IDLE;
          end
        end
        default: begin
          state_reg <= AICC_H_IDLE;
        end
      endcase
    end
  end

endmodule

// >>> dv/aicc_sva.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Bus protocol checker between processor end and converter end
// -----------------------------------------------------------------------------
module aicc_sva
  import aicc_pkg::*;
#(
  parameter int SAMPLE_CYC = 4,
  parameter int CONV_CYC = 8
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic sys_rst,
  // Local bus
  input wire logic [7:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata,
  input wire logic io_rvalid,
  input wire logic eoc_irq
);
  // Slack of four cycles covers the register stages around the count.
  localparam int EOC_MAX = SAMPLE_CYC + CONV_CYC + 4;
  logic cmd_wr;     // A start command is on the bus.
  logic armed_reg;  // A command is out and its result is not yet in.

  assign cmd_wr = io_wr && (io_addr == AICC_PORT_CMD);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // Tracks whether a conversion was asked for, so a stray finish can be caught.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      armed_reg <= 1'b0;
    end else if (cmd_wr) begin
      armed_reg <= 1'b1;
    end else if (eoc_irq) begin
      armed_reg <= 1'b0;
    end
  end

  chk_read_answer: assert property (io_rd |=> io_rvalid)
    else $error("read strobe got no answer one cycle later");
  chk_answer_cause: assert property (io_rvalid |-> $past(io_rd))
    else $error("read answer without a read strobe");
  chk_start_clears: assert property (cmd_wr |=> !eoc_irq)
    else $error("end flag not cleared by start command");
  chk_no_early_end: assert property (cmd_wr |=> !eoc_irq [*4])
    else $error("end flag rose before sampling time passed");
  chk_end_in_time: assert property (cmd_wr |-> ##[1:EOC_MAX] (eoc_irq || io_wr))
    else $error("conversion did not finish in time");
  chk_end_needs_cmd: assert property ($rose(eoc_irq) |-> armed_reg)
    else $error("end flag rose without a start command");
  chk_end_holds: assert property (eoc_irq && !cmd_wr |=> eoc_irq)
    else $error("end request dropped without a new command");
  chk_data_stands: assert property (!io_rvalid |-> $stable(io_rdata))
    else $error("read data changed without a read");
  chk_high_status: assert property (io_rvalid && $past(io_rd) && ($past(io_addr) ==
      AICC_PORT_HIGH) |-> io_rdata[AICC_HI_EOC_BIT] == $past(eoc_irq) &&
      io_rdata[5:4] == 2'h0)
    else $error("high byte status fields wrong");

  cov_start: cover property (cmd_wr);
  cov_end: cover property ($rose(eoc_irq));
  cov_high_read: cover property (io_rd && io_addr == AICC_PORT_HIGH);
endmodule

// >>> dv/aicc_test.sv
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Processor end against converter end, driven from the user and analog sides
// -----------------------------------------------------------------------------
module aicc_test;
  import aicc_pkg::*;
  localparam int SAMPLE_CYC = 4;  // Short acquisition count for simulation.
  localparam int CONV_CYC = 8;    // Short conversion bound for simulation.
  localparam int SETTLE_CYC = 40; // Short host wait, same for every gain.
  logic sys_clk, sys_rst, req_valid, req_use_irq, req_ready, res_valid;
  logic [7:0] req_cmd;
  logic [11:0] res_data, adc_raw;
  logic [4:0] mux_sel;
  logic [1:0] pga_gain;
  logic mux_diff, sh_hold, sar_start, adc_done;
  logic [11:0] ref_res; // Reference channel reading for offset removal.
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0; // Free-running cycle count for timing checks.

  aicc_if bus ();
  aicc_dev #(.SAMPLE_CYC(SAMPLE_CYC), .CONV_CYC(CONV_CYC)) u_aicc_dev (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .mux_sel(mux_sel),
    .mux_diff(mux_diff), .pga_gain(pga_gain), .sh_hold(sh_hold), .sar_start(sar_start),
    .adc_raw(adc_raw), .adc_done(adc_done));
  aicc_host #(.SETTLE1_CYC(SETTLE_CYC), .SETTLE5_CYC(SETTLE_CYC), .SETTLE50_CYC(SETTLE_CYC),
    .SETTLE250_CYC(SETTLE_CYC)) u_aicc_host (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .bus(bus), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_use_irq(req_use_irq), .req_ready(req_ready),
    .res_data(res_data), .res_valid(res_valid));
  aicc_sva #(.SAMPLE_CYC(SAMPLE_CYC), .CONV_CYC(CONV_CYC)) u_aicc_sva (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .io_addr(bus.io_addr), .io_wr(bus.io_wr),
    .io_rd(bus.io_rd), .io_wdata(bus.io_wdata), .io_rdata(bus.io_rdata),
    .io_rvalid(bus.io_rvalid), .eoc_irq(bus.eoc_irq));

  // Clock at 100 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Cycle counter used to measure spacing between events.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
  end

  // Compares a result value, at most twelve bits wide.
  task automatic check_val(input string what, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compares a measured span against its least allowed number of cycles.
  task automatic check_min(input string what, input int lo, input int got);
    num_checks++;
    if (got < lo) begin
      n_mismatch++;
      $display("wrong value %s expected at least %0d seen %0d", what, lo, got);
    end
  endtask

  // A wait that runs out of cycles counts as a mismatch.
  task automatic note_limit(input string what, input int n, input int lim);
    if (n >= lim) begin
      n_mismatch++;
      $display("wrong value %s expected done within %0d seen timeout", what, lim);
    end
  endtask

  // Prints the counts and the verdict, then stops the run.
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One full request: command, optional early finish from the converter, two-byte
  // readback by the host, then the host's settling wait. Inputs change at negedge.
  task automatic run_conv(input logic [7:0] cmd, input logic use_irq, input logic [11:0] raw,
                          input logic give_done, input logic [11:0] exp_res);
    int n;
    int t_wr;
    logic [4:0] exp_ch;
    exp_ch = cmd[7] ? {1'b0, cmd[3:0]} : cmd[4:0];
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge sys_clk);
      n++;
    end
    note_limit("ready for start", n, 500);
    adc_raw = raw;
    req_cmd = cmd;
    req_use_irq = use_irq;
    req_valid = 1'b1;
    @(negedge sys_clk);
    req_valid = 1'b0;
    n = 0;
    while (bus.io_wr !== 1'b1 && n < 50) begin
      @(negedge sys_clk);
      n++;
    end
    note_limit("start write", n, 50);
    t_wr = cyc;
    while (sar_start !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    note_limit("start pulse", n, 100);
    check_min("sample span", SAMPLE_CYC, cyc - t_wr);
    check_val("hold state", 12'h001, {11'h000, sh_hold});
    check_val("channel", {7'h00, exp_ch}, {7'h00, mux_sel});
    check_val("bipolar", {11'h000, cmd[7]}, {11'h000, mux_diff});
    check_val("gain", {10'h000, cmd[6:5]}, {10'h000, pga_gain});
    if (give_done) begin
      @(negedge sys_clk);
      @(negedge sys_clk);
      adc_done = 1'b1;
      @(negedge sys_clk);
      adc_done = 1'b0;
    end
    n = 0;
    while (res_valid !== 1'b1 && n < 200) begin
      @(negedge sys_clk);
      n++;
    end
    note_limit("result", n, 200);
    check_val("result", exp_res, res_data);
    check_val("end request", 12'h001, {11'h000, bus.eoc_irq});
    n = 0;
    while (req_ready !== 1'b1 && n < 500) begin
      @(negedge sys_clk);
      n++;
    end
    note_limit("ready after settle", n, 500);
    check_min("settle span", SETTLE_CYC, cyc - t_wr);
  endtask

  // Main sequence: reset, a stray finish pulse, then seven requests covering all four gain codes.
  initial begin
    sys_rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = 8'h00;
    req_use_irq = 1'b0;
    adc_raw = 12'h000;
    adc_done = 1'b0;
    repeat (8) @(negedge sys_clk);
    sys_rst = 1'b0;
    @(negedge sys_clk);
    adc_done = 1'b1;
    @(negedge sys_clk);
    adc_done = 1'b0;
    repeat (3) @(negedge sys_clk);
    check_val("idle end request", 12'h000, {11'h000, bus.eoc_irq});
    run_conv(8'h1f, 1'b0, 12'hab5, 1'b1, 12'hab5);
    run_conv(8'hbf, 1'b1, 12'h900, 1'b1, 12'h100);
    run_conv(8'hc5, 1'b0, 12'h700, 1'b0, 12'h900);
    run_conv(8'h6a, 1'b1, 12'h000, 1'b1, 12'h000);
    run_conv(8'h00, 1'b0, 12'hfff, 1'b1, 12'hfff);
    // High gain: read a reference channel, then remove its offset from another.
    run_conv(8'h60, 1'b0, 12'h010, 1'b1, 12'h010);
    ref_res = res_data;
    run_conv(8'h63, 1'b1, 12'h345, 1'b0, 12'h345);
    check_val("offset corrected", 12'h335, res_data - ref_res);
    end_of_test();
  end

  // Watchdog: the whole sequence needs well under a thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test();
  end
endmodule
